// ### common/serial_consts.svh
// Offsets, field positions, reset values and timing counts of the serial block
// Assumes inclusion by bare name from design and testbench files
`ifndef SERIAL_CONSTS_SVH
`define SERIAL_CONSTS_SVH
`define STATUS_OFFSET     12'h000
`define DATA_OFFSET       12'h004
`define CONTROL_OFFSET    12'h008
`define STATUS_RESET      8'hC0
`define BIT_TX_EMPTY      7
`define BIT_TX_DONE       6
`define BIT_RX_FULL       5
`define BIT_IDLE          4
`define BIT_OVERRUN       3
`define BIT_NOISE         2
`define BIT_FRAMING       1
`define BIT_PARITY        0
`define CTL_TX_EMPTY_IE   7
`define CTL_TX_DONE_IE    6
`define CTL_RX_IE         5
`define CTL_LINE_QUIET_IE 4
`define CTL_TX_EN         3
`define CTL_RX_EN         2
`define CTL_PARITY_EN     1
`define CTL_PARITY_IE     0
`define OVERSAMPLE        16
`define BAUD_DIV_RESET    16'h0036
`endif

// ### common/serial_pkg.sv
// Types shared by the serial status block
// Assumes serial_consts.svh on the include path
package serial_pkg;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_e;
    typedef struct packed {
        logic       rx_word_ready;
        logic       framing;
        logic       noise;
        logic       parity;
    } rx_event_s;
endpackage : serial_pkg

// ### hdl/serial_status.sv
// Serial interface with status flags, noise checks and one shared interrupt
// Assumes APB master on mclk, rxd already synchronous to mclk
// Functional notes
// - Start edge noisy unless after three highs, with samples 3,5,7 low.
// - Any of start samples 8, 9, 10 high sets noise flag.
// - Data bit is majority of samples 8-10; disagreement sets noise.
// - Wait mode leaves operation intact; enabled events wake the device.
// - Halt freezes registers and serial activity; no wake from halt.
// - All events except noise and framing share one request, gated by enables and global mask.
// - Event and enable pairing as listed for each flag.
// - Status is read-only, eight bits, reset value C0h.
// - Tx empty sets on transfer to shifter; clears by status then write.
// - No transfer to shifter while tx empty flag is set.
// - Tx complete sets after data frame only; clears by status then write.
// - Rx full sets on word moved to data; clears by status then read.
// - Idle sets on idle line, re-arms only after rx full sets.
// - Overrun keeps held word, shift register overwritten.
// - Noise flag sets on noisy frame, no own interrupt.
// - Framing flag on desync or break, no own interrupt.
// - Framing plus overrun: only overrun flag set.
// - Parity flag on mismatch, interrupts if enabled.
// - False start discards frame, noise kept for next valid frame.
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "serial_consts.svh"
module serial_status
    import serial_pkg::*;
#(
    parameter logic [15:0] BAUD_DIV = `BAUD_DIV_RESET
) (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rxd,
    output logic             txd,
    input  wire logic        wait_mode,
    input  wire logic        halt_mode,
    input  wire logic        global_irq_mask,
    output logic             irq_req,
    output logic             wake_req
);
    logic [7:0]  status;
    logic [7:0]  control;
    logic [7:0]  rx_holding_reg;
    logic [7:0]  tx_holding_reg;
    logic        status_seen;
    logic        tx_loaded;
    logic        idle_armed;
    logic        noise_pending;
    logic [15:0] tick_cnt;
    logic        tick;
    logic [2:0]  hist;
    logic [3:0]  rx_smp;
    logic [3:0]  rx_bit;
    logic [8:0]  rx_shift;
    logic [2:0]  maj;
    logic        rx_noise;
    logic [4:0]  idle_cnt;
    logic [3:0]  tx_smp;
    logic [3:0]  tx_bit;
    logic [8:0]  tx_shift;
    rx_state_e   rx_state;
    tx_state_e   tx_state;
    rx_event_s   rx_ev;

    function automatic logic majority(input logic [2:0] s);
        return (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
    endfunction : majority

    // Any split among the three middle samples is noise, not only a lone outlier
    function automatic logic disagree(input logic [2:0] s);
        return (s != 3'h0) & (s != 3'h7);
    endfunction : disagree

    wire access   = psel & penable;
    wire st_rd    = access & ~pwrite & (paddr == `STATUS_OFFSET);
    wire dr_rd    = access & ~pwrite & (paddr == `DATA_OFFSET);
    wire dr_wr    = access & pwrite & (paddr == `DATA_OFFSET);
    wire ctl_wr   = access & pwrite & (paddr == `CONTROL_OFFSET);
    wire mapped   = (paddr == `STATUS_OFFSET) | (paddr == `DATA_OFFSET) | (paddr == `CONTROL_OFFSET);
    // Status is read-only; a write there counts as an access but stores nothing
    wire st_acc   = access & (paddr == `STATUS_OFFSET);
    wire run      = ~halt_mode;
    wire clr_rx   = status_seen & dr_rd;
    wire clr_tx   = status_seen & dr_wr;
    wire parity_rx = ^rx_shift[7:0] ^ rx_shift[8];
    wire tx_move  = run & tick & (tx_state == TX_IDLE) & tx_loaded & ~status[`BIT_TX_EMPTY]
                    & control[`CTL_TX_EN];
    wire tx_done  = run & tick & (tx_state == TX_STOP) & (tx_smp == 4'hF);

    // APB slave, zero wait states
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (psel & ~penable & ~pwrite) begin
                unique case (paddr)
                    `STATUS_OFFSET:  prdata <= {24'h00_0000, status};
                    `DATA_OFFSET:    prdata <= {24'h00_0000, rx_holding_reg};
                    `CONTROL_OFFSET: prdata <= {24'h00_0000, control};
                    default:         prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Control register steers enables and the transmitter
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            control <= 8'h00;
        else if (ctl_wr & pready & run)
            control <= pwdata[7:0];
    end

    // Remembered status access for the two-step clear
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            status_seen <= 1'b0;
        else if (st_acc & pready & run)
            status_seen <= 1'b1;
        else if ((dr_rd | dr_wr) & pready & run)
            status_seen <= 1'b0;
    end

    // Transmit holding register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tx_holding_reg <= 8'h00;
            tx_loaded      <= 1'b0;
        end else if (dr_wr & pready & run) begin
            tx_holding_reg <= pwdata[7:0];
            tx_loaded      <= 1'b1;
        end else if (tx_move) begin
            tx_loaded      <= 1'b0;
        end
    end

    // Oversampling tick, sixteen per bit
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tick_cnt <= 16'h0000;
            tick     <= 1'b0;
        end else if (run) begin
            tick     <= (tick_cnt == 16'h0000);
            tick_cnt <= (tick_cnt == 16'h0000) ? BAUD_DIV - 16'h0001 : tick_cnt - 16'h0001;
        end
    end

    // Transmitter: start, 8 data, parity bit when enabled, stop
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tx_state <= TX_IDLE;
            tx_smp   <= 4'h0;
            tx_bit   <= 4'h0;
            tx_shift <= 9'h1FF;
            txd      <= 1'b1;
        end else if (run & tick) begin
            tx_smp <= tx_smp + 4'h1;
            unique case (tx_state)
                TX_IDLE: begin
                    txd <= 1'b1;
                    if (tx_move) begin
                        tx_shift <= {^tx_holding_reg, tx_holding_reg};
                        tx_state <= TX_START;
                        tx_smp   <= 4'h0;
                    end
                end
                TX_START: begin
                    txd <= 1'b0;
                    if (tx_smp == 4'hF) begin
                        tx_state <= TX_DATA;
                        tx_bit   <= 4'h0;
                    end
                end
                TX_DATA: begin
                    txd <= tx_shift[0];
                    if (tx_smp == 4'hF) begin
                        tx_shift <= {1'b1, tx_shift[8:1]};
                        tx_bit   <= tx_bit + 4'h1;
                        if (tx_bit == (control[`CTL_PARITY_EN] ? 4'h8 : 4'h7))
                            tx_state <= TX_STOP;
                    end
                end
                TX_STOP: begin
                    txd <= 1'b1;
                    if (tx_smp == 4'hF)
                        tx_state <= TX_IDLE;
                end
            endcase
        end
    end

    // Receiver with start-edge qualification and majority sampling
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rx_state      <= RX_IDLE;
            hist          <= 3'h7;
            rx_smp        <= 4'h0;
            rx_bit        <= 4'h0;
            rx_shift      <= 9'h000;
            maj           <= 3'h0;
            rx_noise      <= 1'b0;
            noise_pending <= 1'b0;
            rx_ev         <= '0;
            idle_cnt      <= 5'h00;
        end else begin
            // Held through halt so a finished word is not lost
            if (run)
                rx_ev <= '0;
            if (run & tick & control[`CTL_RX_EN]) begin
                hist   <= {hist[1:0], rxd};
                rx_smp <= rx_smp + 4'h1;
                if (rx_smp == 4'h7 | rx_smp == 4'h8 | rx_smp == 4'h9)
                    maj <= {maj[1:0], rxd};
                unique case (rx_state)
                    RX_IDLE: begin
                        idle_cnt <= rxd ? ((idle_cnt == 5'h1F) ? idle_cnt : idle_cnt + 5'h01) : 5'h00;
                        if (!rxd) begin
                            rx_state <= RX_START;
                            rx_smp   <= 4'h1;
                            // Edge without three preceding highs is noisy
                            rx_noise <= noise_pending | (hist != 3'h7);
                        end
                    end
                    RX_START: begin
                        if ((rx_smp == 4'h2 | rx_smp == 4'h4 | rx_smp == 4'h6) & rxd)
                            rx_noise <= 1'b1;
                        if (rx_smp == 4'hF) begin
                            if (maj != 3'h0) begin
                                // False start: drop frame, hold noise for next one
                                noise_pending <= 1'b1;
                                rx_state      <= RX_IDLE;
                            end else begin
                                rx_state <= RX_DATA;
                                rx_bit   <= 4'h0;
                            end
                        end
                    end
                    RX_DATA: begin
                        if (rx_smp == 4'hF) begin
                            rx_shift <= {majority(maj), rx_shift[8:1]};
                            if (disagree(maj))
                                rx_noise <= 1'b1;
                            rx_bit <= rx_bit + 4'h1;
                            if (rx_bit == 4'h8)
                                rx_state <= RX_STOP;
                        end
                    end
                    RX_STOP: begin
                        if (rx_smp == 4'hF) begin
                            rx_state            <= RX_IDLE;
                            idle_cnt            <= 5'h00;
                            noise_pending       <= 1'b0;
                            rx_ev.rx_word_ready <= 1'b1;
                            rx_ev.framing       <= ~majority(maj) | (rx_shift == 9'h000);
                            rx_ev.noise         <= rx_noise | disagree(maj);
                            rx_ev.parity        <= control[`CTL_PARITY_EN] & parity_rx;
                        end
                    end
                endcase
            end
        end
    end

    // Received word hand-over and overrun
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            rx_holding_reg <= 8'h00;
        else if (run & rx_ev.rx_word_ready & (~status[`BIT_RX_FULL] | clr_rx & pready))
            rx_holding_reg <= rx_shift[7:0];
    end

    // Status flags; a hardware set wins over a same-cycle clear
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            status     <= `STATUS_RESET;
            idle_armed <= 1'b1;
        end else if (run) begin
            if (clr_tx & pready) begin
                status[`BIT_TX_EMPTY] <= 1'b0;
                status[`BIT_TX_DONE]  <= 1'b0;
            end
            if (tx_move)
                status[`BIT_TX_EMPTY] <= 1'b1;
            // Only data frames reach this point, never preamble or break
            if (tx_done)
                status[`BIT_TX_DONE] <= 1'b1;
            if (clr_rx & pready) begin
                status[`BIT_RX_FULL:`BIT_PARITY] <= 6'h00;
                if (status[`BIT_IDLE])
                    idle_armed <= 1'b0;
            end
            if (rx_ev.rx_word_ready) begin
                if (status[`BIT_RX_FULL] & ~(clr_rx & pready)) begin
                    status[`BIT_OVERRUN] <= 1'b1;
                end else begin
                    status[`BIT_RX_FULL] <= 1'b1;
                    idle_armed           <= 1'b1;
                    if (rx_ev.noise)
                        status[`BIT_NOISE] <= 1'b1;
                    if (rx_ev.framing)
                        status[`BIT_FRAMING] <= 1'b1;
                    if (rx_ev.parity)
                        status[`BIT_PARITY] <= 1'b1;
                end
            end
            if (idle_cnt == 5'h10 & idle_armed & tick & rx_state == RX_IDLE) begin
                status[`BIT_IDLE] <= 1'b1;
                idle_armed        <= 1'b0;
            end
        end
    end

    // Shared request; noise and framing have no enable of their own
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_req  <= 1'b0;
            wake_req <= 1'b0;
        end else begin
            irq_req <= ~global_irq_mask & (
                       (status[`BIT_TX_EMPTY] & control[`CTL_TX_EMPTY_IE])
                     | (status[`BIT_TX_DONE] & control[`CTL_TX_DONE_IE])
                     | ((status[`BIT_RX_FULL] | status[`BIT_OVERRUN]) & control[`CTL_RX_IE])
                     | (status[`BIT_IDLE] & control[`CTL_LINE_QUIET_IE])
                     | (status[`BIT_PARITY] & control[`CTL_PARITY_IE]));
            wake_req <= wait_mode & ~halt_mode & (
                       (status[`BIT_TX_EMPTY] & control[`CTL_TX_EMPTY_IE])
                     | (status[`BIT_TX_DONE] & control[`CTL_TX_DONE_IE])
                     | ((status[`BIT_RX_FULL] | status[`BIT_OVERRUN]) & control[`CTL_RX_IE])
                     | (status[`BIT_IDLE] & control[`CTL_LINE_QUIET_IE])
                     | (status[`BIT_PARITY] & control[`CTL_PARITY_IE]));
        end
    end
endmodule : serial_status

// ### testbench/serial_line_model.sv
// Far end of the serial line: frame sender on rxd, byte catcher on txd
// Assumes one oversample tick per mclk, so 16 mclk per bit
`timescale 1ns/1ps
module serial_line_model
    import serial_pkg::*;
(
    input  wire logic mclk,
    input  wire logic txd,
    output logic      rxd
);
    initial rxd = 1'b1;

    // Modes: 0 clean, 1 noisy data bit, 2 low stop, 3 false start, 4 bad parity
    task send(input logic [7:0] d, input int mode);
        logic [10:0] f;
        int          k;
        begin
            f = {mode != 2, ^d ^ (mode == 4), d, 1'b0};
            for (k = 0; k < 176; k++) begin
                @(posedge mclk);
                rxd <= mode == 3 ? k > 1 : f[k / 16] ^ (mode == 1 && k == 24);
            end
            @(posedge mclk);
            rxd <= 1'b1;
            repeat (32) @(posedge mclk);
        end
    endtask : send

    // Mid-bit sampling, data bits only
    task recv(output logic [7:0] d);
        int k;
        begin
            @(negedge txd);
            repeat (8) @(posedge mclk);
            for (k = 0; k < 8; k++) begin
                repeat (16) @(posedge mclk);
                d[k] = txd;
            end
        end
    endtask : recv
endmodule : serial_line_model

// ### testbench/serial_status_chk.sv
// Port-level checker for the serial status block
// Assumes mclk clock and async active-low nrst; bound at the foot
`timescale 1ns/1ps
`include "serial_consts.svh"
module serial_status_chk
    import serial_pkg::*;
#(
    parameter logic [15:0] BAUD_DIV = `BAUD_DIV_RESET
) (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rxd,
    input wire logic        txd,
    input wire logic        wait_mode,
    input wire logic        halt_mode,
    input wire logic        global_irq_mask,
    input wire logic        irq_req,
    input wire logic        wake_req
);
    logic [7:0] ctl_seen;
    logic [7:0] last_st;
    logic       data_hit;
    logic       tx_armed;
    wire logic  done_acc = psel && penable && pready;

    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    // Shadow of enables; halt drops control writes
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) ctl_seen <= 8'h00;
        else if (done_acc && pwrite && paddr == `CONTROL_OFFSET && !halt_mode) ctl_seen <= pwdata[7:0];
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            last_st  <= 8'h00;
            data_hit <= 1'b0;
        end else if (done_acc && !pwrite && paddr == `STATUS_OFFSET) begin
            last_st  <= prdata[7:0];
            data_hit <= 1'b0;
        end else if (done_acc && paddr == `DATA_OFFSET) begin
            data_hit <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) tx_armed <= 1'b0;
        else if (done_acc && pwrite && paddr == `DATA_OFFSET) tx_armed <= 1'b1;
    end

    chk_mask_blocks: assert property (
        global_irq_mask && $past(global_irq_mask) |-> !irq_req) else $error("irq_req while masked");
    chk_enables_off: assert property (
        (ctl_seen & 8'hF1) == 8'h00 && ($past(ctl_seen) & 8'hF1) == 8'h00 |-> !irq_req)
        else $error("irq_req with no enable set");
    chk_halt_no_wake: assert property (
        halt_mode && $past(halt_mode) |-> !wake_req) else $error("wake_req in halt");
    chk_halt_freeze: assert property (
        halt_mode && $past(halt_mode) && $past(halt_mode, 2) |-> $stable(txd)) else $error("txd moved in halt");
    chk_run_no_wake: assert property (
        !wait_mode && !$past(wait_mode) |-> !wake_req) else $error("wake_req outside wait");
    chk_wait_wakes: assert property (
        irq_req && $past(irq_req) && wait_mode && $past(wait_mode) && !halt_mode && !$past(halt_mode)
        |-> wake_req) else $error("no wake_req in wait");
    chk_status_width: assert property (
        done_acc && !pwrite && paddr == `STATUS_OFFSET |-> prdata[31:8] == 24'h0) else $error("status upper bits");
    chk_flags_sticky: assert property (
        done_acc && !pwrite && paddr == `STATUS_OFFSET && !data_hit |-> (prdata[7:0] & last_st) == last_st)
        else $error("flag cleared without data access");
    chk_tx_waits: assert property (
        !tx_armed |-> txd) else $error("txd left idle before any data write");
endmodule : serial_status_chk

bind serial_status serial_status_chk #(.BAUD_DIV(BAUD_DIV)) chk_u (.mclk, .nrst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rxd, .txd, .wait_mode, .halt_mode, .global_irq_mask,
    .irq_req, .wake_req);

// ### testbench/serial_status_tb.sv
// Bench for the serial status block: APB tasks and line partner
// Assumes BAUD_DIV of 1, so one oversample tick per mclk
`timescale 1ns/1ps
`include "serial_consts.svh"
module serial_status_tb
    import serial_pkg::*;
;
    localparam logic [11:0] stat_a = `STATUS_OFFSET;
    localparam logic [11:0] data_a = `DATA_OFFSET;
    localparam logic [11:0] ctl_a  = `CONTROL_OFFSET;
    logic        mclk, nrst, psel, penable, pwrite, pready, pslverr, rxd, txd, e;
    logic        wait_mode, halt_mode, global_irq_mask, irq_req, wake_req;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0]  b;
    int          bad_count, compares, i;

    serial_status #(.BAUD_DIV(16'h0001)) dut_u (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .rxd, .txd, .wait_mode, .halt_mode, .global_irq_mask, .irq_req, .wake_req);
    serial_line_model line_u (.mclk, .txd, .rxd);

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task tally_and_finish;
        begin
            $display("Compares %0d, mismatches %0d", compares, bad_count);
            if (bad_count == 0 && compares > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask : tally_and_finish

    task check(input logic [31:0] got, input logic [31:0] exp);
        begin
            compares++;
            if (got !== exp) begin
                bad_count++;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask : check

    // Entered just after a rising edge; holds the request until pready
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        begin
            psel    <= 1'b1;
            penable <= 1'b0;
            pwrite  <= w;
            paddr   <= a;
            pwdata  <= {24'h0, d};
            @(posedge mclk);
            penable <= 1'b1;
            // Waits as long as the slave needs; only the watchdog ends a hang
            do begin
                @(posedge mclk);
            end while (pready !== 1'b1);
            q = prdata;
            e = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge mclk);
        end
    endtask : apb

    task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        begin
            apb(1'b0, a, 8'h00);
            check(q & m, x);
        end
    endtask : rd

    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata, wait_mode, halt_mode} = '0;
        global_irq_mask = 1'b1;
        bad_count = 0;
        compares = 0;
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        rd(stat_a, 32'hFFFFFFFF, 32'hC0);
        apb(1'b1, stat_a, 8'h3F);
        rd(stat_a, 32'hFF, 32'hC0);
        rd(12'h00C, 32'hFFFFFFFF, 32'h0);
        check(e, 1'b1);
        apb(1'b1, ctl_a, 8'h2F);
        line_u.send(8'h00, 3);
        line_u.send(8'h5A, 0);
        rd(stat_a, 32'h2F, 32'h24);
        check(irq_req, 1'b0);
        global_irq_mask <= 1'b0;
        repeat (3) @(posedge mclk);
        check(irq_req, 1'b1);
        wait_mode <= 1'b1;
        repeat (3) @(posedge mclk);
        check(wake_req, 1'b1);
        halt_mode <= 1'b1;
        repeat (3) @(posedge mclk);
        check(wake_req, 1'b0);
        wait_mode <= 1'b0;
        halt_mode <= 1'b0;
        rd(data_a, 32'hFF, 32'h5A);
        rd(stat_a, 32'h3F, 32'h0);
        repeat (60) @(posedge mclk);
        rd(stat_a, 32'h3F, 32'h0);
        apb(1'b1, ctl_a, 8'h04);
        line_u.send(8'h11, 0);
        line_u.send(8'h22, 2);
        rd(stat_a, 32'h2B, 32'h28);
        check(irq_req, 1'b0);
        rd(data_a, 32'hFF, 32'h11);
        apb(1'b0, stat_a, 8'h00);
        apb(1'b0, data_a, 8'h00);
        for (i = 0; i < 2; i++) begin
            line_u.send(8'(8'h33 + i), i + 1);
            rd(stat_a, 32'h27, i ? 32'h22 : 32'h24);
            check(irq_req, 1'b0);
            rd(data_a, 32'hFF, 32'h33 + i);
        end
        apb(1'b1, ctl_a, 8'h07);
        line_u.send(8'h55, 4);
        rd(stat_a, 32'h25, 32'h21);
        repeat (2) @(posedge mclk);
        check(irq_req, 1'b1);
        rd(data_a, 32'hFF, 32'h55);
        repeat (3) @(posedge mclk);
        check(irq_req, 1'b0);
        apb(1'b1, ctl_a, 8'h0C);
        fork
            line_u.recv(b);
            begin
                rd(stat_a, 32'hC0, 32'hC0);
                apb(1'b1, data_a, 8'hA5);
                rd(stat_a, 32'h40, 32'h00);
            end
        join
        check(b, 8'hA5);
        repeat (60) @(posedge mclk);
        rd(stat_a, 32'hC0, 32'hC0);
        apb(1'b0, data_a, 8'h00);
        apb(1'b1, data_a, 8'h3C);
        i = 0;
        repeat (200) begin
            @(posedge mclk);
            if (txd !== 1'b1) i++;
        end
        check(i, 0);
        tally_and_finish();
    end
endmodule : serial_status_tb
